// ---- inc/ifepb_map.svh ----
`ifndef IFEPB_MAP_SVH
`define IFEPB_MAP_SVH

// Register byte offsets
`define IFEPB_OFF_FLAG      8'h00
`define IFEPB_OFF_ENABLE    8'h04
`define IFEPB_OFF_PRIO_BASE 8'h10
`define IFEPB_OFF_STATUS    8'h08
`define IFEPB_OFF_EVSTAT    8'h0C
`define IFEPB_OFF_EVMASK    8'h30

// Priority word field layout, lane n at bits 8n+4..8n
`define IFEPB_LANE_W        8
`define IFEPB_PRIO_LSB      2
`define IFEPB_SUB_LSB       0
`define IFEPB_LANE_MASK     8'h1F

// Presented status word layout
`define IFEPB_STAT_PRI_LSB  8
`define IFEPB_STAT_VEC_LSB  0

// Reset values
`define IFEPB_RST_WORD      32'h0000_0000

`endif

// ---- inc/ifepb_pkg.sv ----
package ifepb_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ifepb_bus_req_t;

  typedef struct packed {
    logic [2:0] prio;
    logic [1:0] sub;
  } ifepb_level_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] vec;
    logic [2:0] prio;
  } ifepb_present_t;

  typedef enum logic [1:0] {
    IFEPB_IDLE    = 2'b00,
    IFEPB_PRESENT = 2'b01
  } ifepb_state_t;

endpackage

// ---- hw/ifepb_prio_mem.sv ----
`include "ifepb_map.svh"

module ifepb_prio_mem #(
  parameter int WORDS = 8,
  parameter int AW    = (WORDS > 1) ? $clog2(WORDS) : 1
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     reset_n_in,
  // Write port
  input  wire logic                     wr_in,
  input  wire logic [AW-1:0]            waddr_in,
  input  wire logic [31:0]              wdata_in,
  // Registered read port
  input  wire logic [AW-1:0]            raddr_in,
  output logic      [31:0]              rdata_out,
  // Flat view of all words for the arbiter
  output logic      [32*WORDS-1:0]      all_out
);

  logic [31:0] mem_r [WORDS];

  initial begin
    if (WORDS < 1 || WORDS > 8) begin
      $error("ifepb_prio_mem: WORDS out of range");
    end
  end

  // Unused bits never stored, so they read zero
  function automatic logic [31:0] ifepb_keep(input logic [31:0] w);
    ifepb_keep = w & {4{`IFEPB_LANE_MASK}};
  endfunction

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= `IFEPB_RST_WORD;
      end
    end else if (wr_in) begin
      mem_r[waddr_in] <= ifepb_keep(wdata_in);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= `IFEPB_RST_WORD;
    end else begin
      rdata_out <= mem_r[raddr_in];
    end
  end

  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      all_out[32*i +: 32] = mem_r[i];
    end
  end

endmodule

// ---- hw/ifepb_bank.sv ----
// Design decisions made here: strobed register access and the register offsets.
`include "ifepb_map.svh"

module ifepb_bank #(
  parameter int SOURCES = 32
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  // Register port
  input  wire ifepb_pkg::ifepb_bus_req_t bus_in,
  output logic      [31:0]           rdata_out,
  // Source events, one-cycle or level
  input  wire logic [SOURCES-1:0]    src_event_in,
  // Per-source request towards the core
  output logic      [SOURCES-1:0]    src_req_out,
  // Presented interrupt
  output logic                       cpu_req_out,
  output logic      [5:0]            cpu_vec_out,
  output logic      [2:0]            cpu_prio_out,
  // Block interrupt
  output logic                       irq_out
);

  localparam int PWORDS = (SOURCES + 3) / 4;
  localparam int PAW    = (PWORDS > 1) ? $clog2(PWORDS) : 1;

  initial begin
    if (SOURCES < 1 || SOURCES > 32) begin
      $error("ifepb_bank: SOURCES must be 1..32");
    end
  end

  logic [SOURCES-1:0] flag_r;
  logic [SOURCES-1:0] enable_r;
  logic [1:0]         ev_stat_r;
  logic [1:0]         ev_mask_r;
  ifepb_pkg::ifepb_present_t pres_r;
  ifepb_pkg::ifepb_state_t   state_r;
  logic [31:0]        rdata_nxt;
  logic [7:0]         raddr_r;
  logic               rd_r;
  logic [32*PWORDS-1:0] prio_all;
  logic [31:0]        prio_rdata;

  wire logic wr_flag   = bus_in.wr && bus_in.addr == `IFEPB_OFF_FLAG;
  wire logic wr_enable = bus_in.wr && bus_in.addr == `IFEPB_OFF_ENABLE;
  wire logic wr_evstat = bus_in.wr && bus_in.addr == `IFEPB_OFF_EVSTAT;
  wire logic wr_evmask = bus_in.wr && bus_in.addr == `IFEPB_OFF_EVMASK;
  wire logic prio_sel  = bus_in.addr >= `IFEPB_OFF_PRIO_BASE &&
                         bus_in.addr < 8'(`IFEPB_OFF_PRIO_BASE + 4*PWORDS);
  wire logic [PAW-1:0] prio_idx =
    PAW'((bus_in.addr - `IFEPB_OFF_PRIO_BASE) >> 2);

  function automatic ifepb_pkg::ifepb_level_t lane_level(
    input logic [32*PWORDS-1:0] all, input int src);
    logic [7:0] lane;
    lane = all[8*src +: 8];
    lane_level.prio = lane[`IFEPB_PRIO_LSB +: 3];
    lane_level.sub  = lane[`IFEPB_SUB_LSB +: 2];
  endfunction

  ifepb_prio_mem #(
    .WORDS (PWORDS),
    .AW    (PAW)
  ) u_prio (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .wr_in      (bus_in.wr && prio_sel),
    .waddr_in   (prio_idx),
    .wdata_in   (bus_in.wdata),
    .raddr_in   (prio_idx),
    .rdata_out  (prio_rdata),
    .all_out    (prio_all)
  );

  // Flags: software write first, then hardware set on top
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_r <= '0;
    end else begin
      flag_r <= (wr_flag ? bus_in.wdata[SOURCES-1:0] : flag_r)
                | src_event_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_r <= '0;
    end else if (wr_enable) begin
      enable_r <= bus_in.wdata[SOURCES-1:0];
    end
  end

  // Per-source level, decoded once for the request and winner logic
  ifepb_pkg::ifepb_level_t lvl [SOURCES];
  always_comb begin
    for (int i = 0; i < SOURCES; i++) begin
      lvl[i] = lane_level(prio_all, i);
    end
  end

  // Qualified requests
  always_comb begin
    for (int i = 0; i < SOURCES; i++) begin
      src_req_out[i] = flag_r[i] && enable_r[i]
                       && lvl[i].prio != 3'd0;
    end
  end

  // Winner: highest level, then highest subpriority, then lowest index
  ifepb_pkg::ifepb_present_t win;
  logic [4:0] best_key;
  always_comb begin
    win      = '0;
    best_key = '0;
    for (int i = 0; i < SOURCES; i++) begin
      if (src_req_out[i] &&
          (!win.valid || 5'(lvl[i]) > best_key)) begin
        win.valid = 1'b1;
        win.vec   = 6'(i);
        win.prio  = lvl[i].prio;
        best_key  = 5'(lvl[i]);
      end
    end
  end

  // Presentation latch: holds last presented vector for status
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pres_r  <= '0;
      state_r <= ifepb_pkg::IFEPB_IDLE;
    end else begin
      case (state_r)
        ifepb_pkg::IFEPB_IDLE: begin
          if (win.valid) begin
            pres_r  <= win;
            state_r <= ifepb_pkg::IFEPB_PRESENT;
          end
        end
        ifepb_pkg::IFEPB_PRESENT: begin
          if (!win.valid) begin
            pres_r.valid <= 1'b0;
            state_r      <= ifepb_pkg::IFEPB_IDLE;
          end else if (win.vec != pres_r.vec ||
                       win.prio != pres_r.prio) begin
            pres_r <= win;
          end
        end
        default: begin
          state_r <= ifepb_pkg::IFEPB_IDLE;
        end
      endcase
    end
  end

  assign cpu_req_out  = pres_r.valid;
  assign cpu_vec_out  = pres_r.vec;
  assign cpu_prio_out = pres_r.prio;

  // Events: bit0 new presentation, bit1 flag forced by software
  wire logic ev_new   = win.valid &&
                        (state_r == ifepb_pkg::IFEPB_IDLE ||
                         win.vec != pres_r.vec);
  wire logic ev_force = wr_flag &&
                        |(bus_in.wdata[SOURCES-1:0] & ~flag_r);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ev_stat_r <= '0;
    end else begin
      ev_stat_r <= (ev_stat_r & ~(wr_evstat ? bus_in.wdata[1:0] : 2'b00))
                   | {ev_force, ev_new};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ev_mask_r <= '0;
    end else if (wr_evmask) begin
      ev_mask_r <= bus_in.wdata[1:0];
    end
  end

  assign irq_out = |(ev_stat_r & ev_mask_r);

  // Read path: one cycle latency
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      raddr_r <= '0;
      rd_r    <= 1'b0;
    end else begin
      raddr_r <= bus_in.addr;
      rd_r    <= bus_in.rd;
    end
  end

  logic [31:0] snap_nxt;
  always_comb begin
    snap_nxt = '0;
    case (bus_in.addr)
      `IFEPB_OFF_FLAG:   snap_nxt = 32'(flag_r);
      `IFEPB_OFF_ENABLE: snap_nxt = 32'(enable_r);
      `IFEPB_OFF_STATUS: begin
        snap_nxt[`IFEPB_STAT_PRI_LSB +: 3] = pres_r.prio;
        snap_nxt[`IFEPB_STAT_VEC_LSB +: 6] = pres_r.vec;
      end
      `IFEPB_OFF_EVSTAT: snap_nxt = {30'h0, ev_stat_r};
      `IFEPB_OFF_EVMASK: snap_nxt = {30'h0, ev_mask_r};
      default:           snap_nxt = '0;
    endcase
  end

  logic [31:0] snap_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      snap_r <= '0;
    end else begin
      snap_r <= snap_nxt;
    end
  end

  wire logic raddr_prio = raddr_r >= `IFEPB_OFF_PRIO_BASE &&
                          raddr_r < 8'(`IFEPB_OFF_PRIO_BASE + 4*PWORDS);
  always_comb begin
    rdata_nxt = '0;
    if (rd_r) begin
      rdata_nxt = raddr_prio ? prio_rdata : snap_r;
    end
  end
  assign rdata_out = rdata_nxt;

  // Checker helpers, decoded straight from the stored priority words
  logic [2:0]         chk_max_lvl;
  logic [SOURCES-1:0] chk_prio_nz;
  always_comb begin
    logic [2:0] lv;
    lv          = 3'd0;
    chk_max_lvl = 3'd0;
    chk_prio_nz = '0;
    for (int i = 0; i < SOURCES; i++) begin
      lv             = prio_all[`IFEPB_LANE_W*i + `IFEPB_PRIO_LSB +: 3];
      chk_prio_nz[i] = |lv;
      if (src_req_out[i] && lv > chk_max_lvl) begin
        chk_max_lvl = lv;
      end
    end
  end

  // Assertions
  property p_flag_set;
    @(posedge clk_in) disable iff (!reset_n_in)
      src_event_in != '0 |=>
        (flag_r & $past(src_event_in)) == $past(src_event_in);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag lost on event");

  property p_flag_sticky;
    @(posedge clk_in) disable iff (!reset_n_in)
      !wr_flag |=> (flag_r & $past(flag_r)) == $past(flag_r);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without write");

  property p_flag_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      wr_flag |=>
        flag_r == ($past(bus_in.wdata[SOURCES-1:0]) | $past(src_event_in));
  endproperty
  a_flag_write: assert property (p_flag_write)
    else $error("flag write not taken");

  property p_enable_gate;
    @(posedge clk_in) disable iff (!reset_n_in)
      (src_req_out & ~enable_r) == '0;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("disabled source requests");

  property p_prio_zero;
    @(posedge clk_in) disable iff (!reset_n_in)
      (src_req_out & ~chk_prio_nz) == '0;
  endproperty
  a_prio_zero: assert property (p_prio_zero)
    else $error("priority zero source requests");

  property p_req_full;
    @(posedge clk_in) disable iff (!reset_n_in)
      (flag_r & enable_r & chk_prio_nz & ~src_req_out) == '0;
  endproperty
  a_req_full: assert property (p_req_full)
    else $error("qualified source not requesting");

  property p_win_prio;
    @(posedge clk_in) disable iff (!reset_n_in)
      win.valid |-> win.prio == chk_max_lvl;
  endproperty
  a_win_prio: assert property (p_win_prio)
    else $error("lower level won");

  property p_unused_zero;
    @(posedge clk_in) disable iff (!reset_n_in)
      rd_r && raddr_prio |->
        (rdata_out & ~{4{`IFEPB_LANE_MASK}}) == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused priority bits read back");

  sequence s_idle_win;
    state_r == ifepb_pkg::IFEPB_IDLE && win.valid;
  endsequence
  property p_present;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_idle_win |=> cpu_req_out && cpu_vec_out == $past(win.vec)
                     && cpu_prio_out == $past(win.prio);
  endproperty
  a_present: assert property (p_present)
    else $error("presented vector mismatch");

  // Cleared presentation must keep the latest vector and level readable
  property p_status_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      cpu_req_out && !win.valid |=>
        !cpu_req_out && $stable(cpu_vec_out) && $stable(cpu_prio_out);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("latest presentation not kept");

  property p_ev_set;
    @(posedge clk_in) disable iff (!reset_n_in)
      ev_new |=> ev_stat_r[0];
  endproperty
  a_ev_set: assert property (p_ev_set)
    else $error("new presentation event lost");

  property p_reset_clear;
    @(posedge clk_in) !reset_n_in |=>
      flag_r == '0 && enable_r == '0 && prio_all == '0 && !cpu_req_out;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared at reset");

endmodule

// ---- tb/interrupt_flag_enable_priority_bank_tb.sv ----
`include "ifepb_map.svh"

module interrupt_flag_enable_priority_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Sixteen sources keep the run short; upper flag bits read zero
  localparam int NSRC = 16;

  // Stimulus
  logic                      clk_in = 1'b0;
  logic                      reset_n_in;
  ifepb_pkg::ifepb_bus_req_t bus_in;
  logic [NSRC-1:0]           src_event_in;
  // Observed
  logic [31:0]               rdata_out;
  logic [NSRC-1:0]           src_req_out;
  logic                      cpu_req_out;
  logic [5:0]                cpu_vec_out;
  logic [2:0]                cpu_prio_out;
  logic                      irq_out;
  int                        n_mismatch = 0;
  int                        cmp_count = 0;

  ifepb_bank #(.SOURCES(NSRC)) uut (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .bus_in       (bus_in),
    .rdata_out    (rdata_out),
    .src_event_in (src_event_in),
    .src_req_out  (src_req_out),
    .cpu_req_out  (cpu_req_out),
    .cpu_vec_out  (cpu_vec_out),
    .cpu_prio_out (cpu_prio_out),
    .irq_out      (irq_out)
  );

  always #10 clk_in = ~clk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask

  task automatic pulse(input int s);
    @(posedge clk_in);
    src_event_in[s] <= 1'b1;
    @(posedge clk_in);
    src_event_in <= '0;
  endtask

  task automatic sreq(input logic [NSRC-1:0] exp);
    #1;
    chk({16'h0000, src_req_out}, {16'h0000, exp});
  endtask

  // Presentation trails the winner by one cycle; three leaves margin
  task automatic cpu(input logic [5:0] v, input logic [2:0] p);
    repeat (3) @(posedge clk_in);
    #1;
    chk({22'h0, cpu_req_out, cpu_prio_out, cpu_vec_out},
        {22'h0, 1'b1, p, v});
  endtask

  task automatic irq(input logic exp);
    @(posedge clk_in);
    #1;
    chk({31'h0, irq_out}, {31'h0, exp});
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    reset_n_in = 1'b0;
    bus_in = '0;
    src_event_in = '0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(`IFEPB_OFF_FLAG, 32'h0000_0000);
    rd(`IFEPB_OFF_ENABLE, 32'h0000_0000);
    rd(`IFEPB_OFF_PRIO_BASE, 32'h0000_0000);
    rd(`IFEPB_OFF_STATUS, 32'h0000_0000);
    chk({30'h0, cpu_req_out, irq_out}, 32'h0000_0000);
    // Unmapped place: write ignored, read gives zero
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    wr(`IFEPB_OFF_FLAG, 32'hFFFF_FFFF);
    rd(`IFEPB_OFF_FLAG, 32'h0000_FFFF);
    rd(`IFEPB_OFF_EVSTAT, 32'h0000_0002);
    wr(`IFEPB_OFF_FLAG, 32'h0000_0000);
    rd(`IFEPB_OFF_FLAG, 32'h0000_0000);
    wr(`IFEPB_OFF_ENABLE, 32'h0000_A5A5);
    rd(`IFEPB_OFF_ENABLE, 32'h0000_A5A5);
    wr(`IFEPB_OFF_PRIO_BASE, 32'hFFFF_FFFF);
    rd(`IFEPB_OFF_PRIO_BASE, 32'h1F1F_1F1F);
    wr(`IFEPB_OFF_PRIO_BASE, 32'h0000_0000);
    wr(`IFEPB_OFF_ENABLE, 32'h0000_0060);
    pulse(5);
    rd(`IFEPB_OFF_FLAG, 32'h0000_0020);
    sreq(16'h0000);
    // Source 5 sits in lane 1 of word 1: level 3, subpriority 1
    wr(8'h14, 32'h0000_0D00);
    rd(8'h14, 32'h0000_0D00);
    sreq(16'h0020);
    cpu(6'd5, 3'd3);
    rd(`IFEPB_OFF_STATUS, 32'h0000_0305);
    // Source 6 ties on level and wins on subpriority 2
    wr(8'h14, 32'h000E_0D00);
    pulse(6);
    cpu(6'd6, 3'd3);
    sreq(16'h0060);
    wr(`IFEPB_OFF_ENABLE, 32'h0000_0020);
    sreq(16'h0020);
    cpu(6'd5, 3'd3);
    wr(`IFEPB_OFF_ENABLE, 32'h0000_0060);
    // Software clears all flags in the very cycle source 5 fires
    @(posedge clk_in);
    bus_in <= '{addr: `IFEPB_OFF_FLAG, wdata: 32'h0000_0000,
                wr: 1'b1, rd: 1'b0};
    src_event_in[5] <= 1'b1;
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
    src_event_in <= '0;
    rd(`IFEPB_OFF_FLAG, 32'h0000_0020);
    cpu(6'd5, 3'd3);
    // Block interrupt: raise, clear, then mask
    wr(`IFEPB_OFF_EVSTAT, 32'h0000_0003);
    wr(`IFEPB_OFF_EVMASK, 32'h0000_0001);
    irq(1'b0);
    pulse(6);
    cpu(6'd6, 3'd3);
    irq(1'b1);
    wr(`IFEPB_OFF_EVSTAT, 32'h0000_0001);
    rd(`IFEPB_OFF_EVSTAT, 32'h0000_0000);
    irq(1'b0);
    wr(`IFEPB_OFF_EVMASK, 32'h0000_0000);
    wr(8'h14, 32'h1C0E_0D00);
    wr(`IFEPB_OFF_ENABLE, 32'h0000_00E0);
    pulse(7);
    cpu(6'd7, 3'd7);
    irq(1'b0);
    rd(`IFEPB_OFF_EVSTAT, 32'h0000_0001);
    rd(`IFEPB_OFF_STATUS, 32'h0000_0707);
    // Level 000 takes source 7 out despite flag and enable
    wr(8'h14, 32'h000E_0D00);
    sreq(16'h0060);
    rd(`IFEPB_OFF_FLAG, 32'h0000_00E0);
    // No enabled source: request drops, status keeps the latest
    wr(`IFEPB_OFF_ENABLE, 32'h0000_0000);
    rd(`IFEPB_OFF_STATUS, 32'h0000_0306);
    chk({31'h0, cpu_req_out}, 32'h0000_0000);
    wr(`IFEPB_OFF_EVMASK, 32'h0000_0001);
    irq(1'b1);
    // Reset in mid-run clears what software and sources left behind
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(`IFEPB_OFF_FLAG, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(`IFEPB_OFF_STATUS, 32'h0000_0000);
    rd(`IFEPB_OFF_EVMASK, 32'h0000_0000);
    chk({30'h0, cpu_req_out, irq_out}, 32'h0000_0000);
    report_and_stop();
  end
endmodule
